// ### rtl/timer8_wave_pkg.sv
// Package: constants for the 8-bit timer waveform generator
package timer8_wave_pkg;

  // ----------------------------------------------------------------
  // Counter range
  // ----------------------------------------------------------------
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // ----------------------------------------------------------------
  // Waveform modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_PHASE_PWM = 2'h1;
  localparam logic [1:0] MODE_CLEAR_ON_MATCH = 2'h2;
  localparam logic [1:0] MODE_FAST_PWM = 2'h3;

  // ----------------------------------------------------------------
  // Compare output modes
  // ----------------------------------------------------------------
  localparam logic [1:0] CMP_OFF = 2'h0;
  localparam logic [1:0] CMP_TOGGLE = 2'h1;
  localparam logic [1:0] CMP_CLEAR = 2'h2;
  localparam logic [1:0] CMP_SET = 2'h3;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one word apart)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_COMPARE = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CMP_LSB = 2;
  localparam int CTRL_DIR_BIT = 4;
  localparam int CTRL_PRESC_LSB = 5;

  // ----------------------------------------------------------------
  // Status field positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_CMP_BIT = 1;
  localparam int STAT_WAVE_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Prescale divide ratios
  // ----------------------------------------------------------------
  localparam int PRESC_DIV8 = 8;
  localparam int PRESC_DIV64 = 64;
  localparam int PRESC_DIV256 = 256;
  localparam int PRESC_DIV1024 = 1024;

endpackage

// ### rtl/timer8_prescaler.sv
// Module: prescaler producing the one-cycle timer clock enable
`timescale 1ns/1ps
`default_nettype none
module timer8_prescaler
  import timer8_wave_pkg::*;
#(
  parameter int DIV_W = 10
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [2:0] presc_sel_i,
  output logic tick_o
);

  // ----------------------------------------------------------------
  // Free-running divider
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_q; // Shared divider so all taps stay in phase

  // Divider counts every cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // Tap is due when low bits of the divider are all ones
  function automatic logic tap(input logic [DIV_W-1:0] cnt, input int ratio);
    logic [DIV_W-1:0] mask;
    mask = DIV_W'(ratio - 1);
    return (cnt & mask) == mask;
  endfunction

  // ----------------------------------------------------------------
  // Select tap
  // ----------------------------------------------------------------
  // Selections 6 and 7 (external pin) are not provided: timer stops
  always_comb begin
    case (presc_sel_i)
      3'h1: tick_o = 1'b1;
      3'h2: tick_o = tap(div_q, PRESC_DIV8);
      3'h3: tick_o = tap(div_q, PRESC_DIV64);
      3'h4: tick_o = tap(div_q, PRESC_DIV256);
      3'h5: tick_o = tap(div_q, PRESC_DIV1024);
      default: tick_o = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// ### rtl/timer8_ctc_pwm_waveform.sv
// Module: 8-bit timer counter with clear-on-match, fast and phase PWM
//
// Operation
// - Mode 2 clears counter at compare match
// - Mode 2 compare writes unbuffered; missed match wraps
// - Mode 2 sets match flag each period
// - Mode 2 field 1 toggles output on match
// - Mode 2 overflow flag on MAX to zero
// - Mode 3 counts bottom to MAX, then clears
// - Mode 3 overflow flag at MAX
// - Mode 3 field 2/3 clear/set on match
// - Mode 3 extreme compare values give spike/constant
// - Mode 3 field 1 toggles, buffering kept
// - Mode 1 counts up, holds MAX, down
// - Mode 1 range fixed at eight bits
// - Mode 1 overflow flag at bottom
// - Mode 1 field 2 clear up, set down
// - Mode 1 extreme compare values give constant levels
// - Mode 1 output at MAX follows up-match
// - Mode 1 missed up-match still transitions output
// - Pin driven only when direction is output
// - PWM modes buffer compare, others immediate
// - Field zero leaves output state alone
// - Match flag set next timer clock
`timescale 1ns/1ps
`default_nettype none
module timer8_ctc_pwm_waveform
  import timer8_wave_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic port_data_i,
  output logic wave_pin_o,
  output logic wave_pin_oe_n_o,
  output logic compare_match_flag_o,
  output logic overflow_flag_o
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q; // Mode, compare mode, direction, prescale
  logic [CNT_W-1:0] compare_value_q; // Active compare value
  logic [CNT_W-1:0] compare_buf_q; // Software-facing buffer
  logic [CNT_W-1:0] counter_value_q; // Counter
  logic count_down_q; // Phase PWM direction
  logic compare_match_flag_q; // Sticky match flag
  logic overflow_flag_q; // Sticky overflow flag
  logic wave_out_q; // Internal output compare state
  logic match_pend_q; // Match seen, flag due at next tick
  logic block_q; // Counter write blocks next match
  logic ack_q; // Bus answer
  logic [31:0] rdata_q; // Read data
  logic tick; // Timer clock enable

  // Control field decode
  logic [1:0] wave_mode_sel;
  logic [1:0] cmp_out_mode;
  logic dir_out;
  logic [2:0] presc_sel;
  assign wave_mode_sel = ctrl_q[CTRL_MODE_LSB +: 2];
  assign cmp_out_mode = ctrl_q[CTRL_CMP_LSB +: 2];
  assign dir_out = ctrl_q[CTRL_DIR_BIT];
  assign presc_sel = ctrl_q[CTRL_PRESC_LSB +: 3];

  logic is_pwm;
  assign is_pwm = (wave_mode_sel == MODE_FAST_PWM) || (wave_mode_sel == MODE_PHASE_PWM);

  // ----------------------------------------------------------------
  // Timer clock enable
  // ----------------------------------------------------------------
  timer8_prescaler #(
    .DIV_W(10)
  ) u_presc (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .presc_sel_i(presc_sel),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  logic bus_req;
  logic bus_wr;
  logic hit_ctrl;
  logic hit_cmp;
  logic hit_cnt;
  logic hit_stat;
  logic mapped;
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  assign hit_ctrl = wb_adr_i[3:0] == REG_CTRL;
  assign hit_cmp = wb_adr_i[3:0] == REG_COMPARE;
  assign hit_cnt = wb_adr_i[3:0] == REG_COUNT;
  assign hit_stat = wb_adr_i[3:0] == REG_STATUS;
  assign mapped = (wb_adr_i[31:4] == 28'h0000000) && (hit_ctrl || hit_cmp || hit_cnt || hit_stat);

  logic err_q; // Unmapped access answer

  // Single-wait answer; ack or err one cycle after the request
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= bus_req && mapped;
      err_q <= bus_req && !mapped;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;

  // Read data captured at request
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else if (bus_req && !wb_we_i) begin
      if (hit_ctrl) begin
        rdata_q <= {24'h000000, ctrl_q};
      end else if (hit_cmp) begin
        rdata_q <= {24'h000000, compare_buf_q};
      end else if (hit_cnt) begin
        rdata_q <= {24'h000000, counter_value_q};
      end else if (hit_stat) begin
        rdata_q <= {29'h00000000, wave_out_q, compare_match_flag_q, overflow_flag_q};
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end
  assign wb_dat_o = rdata_q;

  // Control register write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (bus_wr && hit_ctrl) begin
      ctrl_q <= wb_dat_i[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Compare value buffering
  // ----------------------------------------------------------------
  logic at_top; // Reload point of the buffer in PWM modes
  assign at_top = counter_value_q == CNT_MAX;

  // Buffer holds software writes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      compare_buf_q <= COMPARE_RESET;
    end else if (bus_wr && hit_cmp) begin
      compare_buf_q <= wb_dat_i[CNT_W-1:0];
    end
  end

  // Active value: immediate outside PWM, loaded at MAX in PWM
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      compare_value_q <= COMPARE_RESET;
    end else if (!is_pwm) begin
      if (bus_wr && hit_cmp) begin
        compare_value_q <= wb_dat_i[CNT_W-1:0];
      end else begin
        compare_value_q <= compare_buf_q;
      end
    end else if (tick && at_top) begin
      compare_value_q <= compare_buf_q;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  logic match;
  logic cnt_wr;
  assign cnt_wr = bus_wr && hit_cnt;
  assign match = (counter_value_q == compare_value_q) && !block_q;

  // A counter write blocks the match at the following timer clock
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      block_q <= 1'b0;
    end else if (cnt_wr) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  // Counting sequence by mode
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      counter_value_q <= CNT_BOTTOM;
      count_down_q <= 1'b0;
    end else if (cnt_wr) begin
      counter_value_q <= wb_dat_i[CNT_W-1:0];
    end else if (tick) begin
      case (wave_mode_sel)
        MODE_CLEAR_ON_MATCH: begin
          // Missed match runs on to MAX and wraps
          if (counter_value_q == compare_value_q) begin
            counter_value_q <= CNT_BOTTOM;
          end else begin
            counter_value_q <= counter_value_q + 1'b1;
          end
        end
        MODE_PHASE_PWM: begin
          // Fixed eight-bit range, holds MAX one tick
          if (!count_down_q) begin
            if (at_top) begin
              // Turn at MAX so MAX stands for one tick only: 510-tick period
              count_down_q <= 1'b1;
              counter_value_q <= counter_value_q - 1'b1;
            end else begin
              counter_value_q <= counter_value_q + 1'b1;
            end
          end else if (counter_value_q == CNT_BOTTOM) begin
            count_down_q <= 1'b0;
            counter_value_q <= counter_value_q + 1'b1;
          end else begin
            counter_value_q <= counter_value_q - 1'b1;
          end
        end
        default: begin
          // Fast PWM and normal: wrap MAX to bottom
          count_down_q <= 1'b0;
          counter_value_q <= counter_value_q + 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  logic ovf_event;
  always_comb begin
    case (wave_mode_sel)
      MODE_FAST_PWM: ovf_event = tick && at_top;
      MODE_PHASE_PWM: ovf_event = tick && count_down_q &&
                                  (counter_value_q == CNT_BOTTOM);
      default: ovf_event = tick && at_top;
    endcase
  end

  // Match registered, flag raised at the next timer clock
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      match_pend_q <= 1'b0;
    end else if (tick) begin
      match_pend_q <= match;
    end
  end

  logic stat_clr_ovf;
  logic stat_clr_cmp;
  assign stat_clr_ovf = bus_wr && hit_stat && wb_dat_i[STAT_OVF_BIT];
  assign stat_clr_cmp = bus_wr && hit_stat && wb_dat_i[STAT_CMP_BIT];

  // Write-one-to-clear; set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      overflow_flag_q <= 1'b0;
      compare_match_flag_q <= 1'b0;
    end else begin
      if (ovf_event) begin
        overflow_flag_q <= 1'b1;
      end else if (stat_clr_ovf) begin
        overflow_flag_q <= 1'b0;
      end
      if (tick && match_pend_q) begin
        compare_match_flag_q <= 1'b1;
      end else if (stat_clr_cmp) begin
        compare_match_flag_q <= 1'b0;
      end
    end
  end
  assign overflow_flag_o = overflow_flag_q;
  assign compare_match_flag_o = compare_match_flag_q;

  // ----------------------------------------------------------------
  // Waveform generator
  // ----------------------------------------------------------------
  logic inv; // Inverting polarity when field is three
  assign inv = cmp_out_mode[0];

  // Output state updated on timer clock only
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wave_out_q <= 1'b0;
    end else if (tick && cmp_out_mode != CMP_OFF) begin
      case (wave_mode_sel)
        MODE_FAST_PWM: begin
          if (cmp_out_mode == CMP_TOGGLE) begin
            if (match) begin
              wave_out_q <= !wave_out_q;
            end
          end else if (at_top) begin
            // Bottom level wins over a match at MAX: constant level
            wave_out_q <= !inv;
          end else if (match) begin
            wave_out_q <= inv;
          end
        end
        MODE_PHASE_PWM: begin
          // Toggle field is reserved here, no action
          if (cmp_out_mode != CMP_TOGGLE) begin
            if (at_top && !count_down_q) begin
              // At MAX show the up-match result unless compare is MAX
              if (compare_value_q == CNT_MAX) begin
                wave_out_q <= !inv;
              end else begin
                wave_out_q <= inv;
              end
            end else if (count_down_q && counter_value_q == CNT_BOTTOM) begin
              // Bottom keeps the down-match level; compare zero stays at the up-match level (low for field 2, high for field 3)
              if (compare_value_q == CNT_BOTTOM) begin
                wave_out_q <= inv;
              end
            end else if (match) begin
              wave_out_q <= count_down_q ? !inv : inv;
            end
          end
        end
        default: begin
          // Non-PWM: toggle, clear or set on match
          if (match) begin
            case (cmp_out_mode)
              CMP_TOGGLE: wave_out_q <= !wave_out_q;
              CMP_CLEAR: wave_out_q <= 1'b0;
              default: wave_out_q <= 1'b1;
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Override only when the compare mode is nonzero; otherwise port data
  assign wave_pin_o = (cmp_out_mode != CMP_OFF) ? wave_out_q : port_data_i;
  assign wave_pin_oe_n_o = !dir_out;

endmodule
`default_nettype wire

// ### dv/timer8_wave_checker.sv
// Checker: bus and pin relations seen at the waveform block's ports
`timescale 1ns/1ps
`default_nettype none
module timer8_wave_checker
  import timer8_wave_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic port_data_i,
  input wire logic wave_pin_o,
  input wire logic wave_pin_oe_n_o,
  input wire logic compare_match_flag_o,
  input wire logic overflow_flag_o
);
  // ----------------------------------------------------------------
  // Shadow of the control byte
  // ----------------------------------------------------------------
  logic take; // Request taken this edge
  logic mapped; // One of the four byte registers
  logic ctrl_w; // Control store
  logic ovf_clr; // Overflow clear write
  logic cmp_clr; // Match clear write
  logic [7:0] ctrl_q; // Mirror, so pin checks need no internals
  assign take = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
  assign mapped = (wb_adr_i[31:4] == 28'h0) && (wb_adr_i[1:0] == 2'h0);
  assign ctrl_w = take & wb_we_i & wb_sel_i[0] & mapped & (wb_adr_i[3:0] == REG_CTRL);
  assign ovf_clr = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == 32'hc) & wb_dat_i[0];
  assign cmp_clr = take & wb_we_i & wb_sel_i[0] & (wb_adr_i == 32'hc) & wb_dat_i[1];
  // Mirror follows the same take edge as the design
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (ctrl_w) begin
      ctrl_q <= wb_dat_i[7:0];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  ack_answer_a: assert property (take && mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped request not acked next cycle");
  err_answer_a: assert property (take && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped request not refused next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  pin_dir_a: assert property (!wb_ack_o |-> wave_pin_oe_n_o == !ctrl_q[CTRL_DIR_BIT])
    else $error("pin enable does not follow direction bit");
  port_pass_a: assert property (ctrl_q[3:2] == CMP_OFF && !wb_ack_o |-> wave_pin_o == port_data_i)
    else $error("port value not passed with compare output off");
  ovf_sticky_a: assert property ($fell(overflow_flag_o) |-> $past(ovf_clr))
    else $error("overflow flag dropped without clear");
  match_sticky_a: assert property ($fell(compare_match_flag_o) |-> $past(cmp_clr))
    else $error("match flag dropped without clear");
  stop_flags_a: assert property ((ctrl_q[7:5] == 3'h0)[*3] |=> !$rose(overflow_flag_o))
    else $error("overflow flag rose while stopped");
  stop_pin_a: assert property ((ctrl_q[7:5] == 3'h0 && ctrl_q[3:2] != CMP_OFF)[*3]
    |-> $stable(wave_pin_o))
    else $error("wave output moved while stopped");
  // Main scenarios reached
  cover property (wb_err_o);
  cover property ($rose(overflow_flag_o));
  cover property ($fell(wave_pin_o) && ctrl_q[1:0] == MODE_PHASE_PWM);
endmodule
`default_nettype wire

// ### dv/timer8_ctc_pwm_waveform_test.sv
// Testbench: register tasks and pin timing tests for the waveform block
`timescale 1ns/1ps
`default_nettype none
module timer8_ctc_pwm_waveform_test
  import timer8_wave_pkg::*;
;
  logic ref_clk_i, rst_i, we, cyc, stb, port_d; // Bench-driven inputs
  logic [31:0] adr, wdat, rd; // Bus request and captured read
  logic [3:0] sel;
  wire logic [31:0] dat_o;
  wire logic ack, err, pin, oe_n, mflag, oflag;
  logic er; // Captured refusal
  int fail_count, check_count, cyc_cnt, n;
  timer8_ctc_pwm_waveform dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .wb_err_o(err), .port_data_i(port_d),
    .wave_pin_o(pin), .wave_pin_oe_n_o(oe_n), .compare_match_flag_o(mflag),
    .overflow_flag_o(oflag));
  // ----------------------------------------------------------------
  // Clock, timeout, report
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Whole run is about 20k cycles; the ceiling leaves room
  always @(posedge ref_clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // ----------------------------------------------------------------
  // Classic single-cycle bus access; waits for ack or err with no local limit
  // ----------------------------------------------------------------
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge ref_clk_i);
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= 4'hf;
    cyc <= 1'b1;
    stb <= 1'b1;
    // No local limit: only the bench ceiling ends a hung wait
    do begin
      @(posedge ref_clk_i);
    end while (ack !== 1'b1 && err !== 1'b1);
    rd = dat_o;
    er = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer({28'h0, a}, 1'b1, {24'h0, d});
  endtask
  // Compare first, then control: prescale 1, pin driven
  task automatic setup(input logic [1:0] m, input logic [1:0] c, input logic [7:0] v);
    wr(REG_COMPARE, v);
    wr(REG_CTRL, {3'h1, 1'b1, c, m});
    repeat (1100) @(posedge ref_clk_i); // Lets buffered compare load
  endtask
  // Length of one whole run of level lvl on the pin, in cycles
  task automatic width(input logic lvl, output int w);
    int t;
    t = 0;
    while (pin === lvl && t < 3000) begin
      @(negedge ref_clk_i);
      t++;
    end
    while (pin !== lvl && t < 3000) begin
      @(negedge ref_clk_i);
      t++;
    end
    w = 0;
    while (pin === lvl && w < 3000) begin
      @(negedge ref_clk_i);
      w++;
    end
  endtask
  task automatic hold(input logic lvl, input int c);
    int bad;
    bad = 0;
    repeat (c) begin
      @(negedge ref_clk_i);
      if (pin !== lvl) bad++;
    end
    chk("steady pin", 0, bad);
  endtask
  task automatic ovf_seen();
    int t;
    wr(REG_STATUS, 8'h03);
    t = 0;
    while (oflag !== 1'b1 && t < 1200) begin
      @(negedge ref_clk_i);
      t++;
    end
    chk("overflow flag", 1, oflag);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_i, we, cyc, stb, port_d} = 5'h10;
    adr = 32'h0;
    wdat = 32'h0;
    sel = 4'h0;
    repeat (16) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    // Reset values, refusal, pass-through
    xfer(32'h0, 1'b0, 32'h0);
    chk("ctrl reset", {24'h0, CTRL_RESET}, rd);
    xfer(32'h4, 1'b0, 32'h0);
    chk("compare reset", {24'h0, COMPARE_RESET}, rd);
    xfer(32'h10, 1'b0, 32'h0);
    chk("unmapped err", 1, er);
    chk("pin enable off", 1, oe_n);
    port_d <= 1'b1;
    @(negedge ref_clk_i);
    chk("port pass", 1, pin);
    $display("test bus done");
    // Clear on match
    setup(MODE_CLEAR_ON_MATCH, CMP_TOGGLE, 8'h04);
    chk("pin enable on", 0, oe_n);
    width(1'b1, n);
    chk("ctc toggle", 5, n);
    wr(REG_STATUS, 8'h03);
    repeat (12) @(posedge ref_clk_i);
    chk("match flag", 1, mflag);
    chk("no overflow", 0, oflag);
    wr(REG_COMPARE, 8'h00);
    width(1'b0, n);
    chk("ctc half rate", 1, n);
    wr(REG_COMPARE, 8'd200);
    wr(REG_COUNT, 8'd150);
    wr(REG_COMPARE, 8'd50);
    ovf_seen();
    width(1'b1, n);
    chk("ctc new top", 51, n);
    $display("test ctc done");
    // Fast PWM
    setup(MODE_FAST_PWM, CMP_CLEAR, 8'd64);
    width(1'b1, n);
    chk("fast high", 65, n);
    width(1'b0, n);
    chk("fast low", 191, n);
    wr(REG_CTRL, {3'h1, 1'b1, CMP_SET, MODE_FAST_PWM});
    width(1'b0, n);
    chk("fast inv low", 65, n);
    ovf_seen();
    setup(MODE_FAST_PWM, CMP_CLEAR, 8'h00);
    width(1'b1, n);
    chk("fast spike", 1, n);
    setup(MODE_FAST_PWM, CMP_CLEAR, 8'hff);
    hold(1'b1, 600);
    setup(MODE_FAST_PWM, CMP_TOGGLE, 8'd64);
    width(1'b1, n);
    chk("fast toggle", 256, n);
    $display("test fast done");
    // Phase correct PWM
    setup(MODE_PHASE_PWM, CMP_CLEAR, 8'd64);
    width(1'b1, n);
    chk("phase high", 128, n);
    width(1'b0, n);
    chk("phase low", 382, n);
    wr(REG_CTRL, {3'h1, 1'b1, CMP_SET, MODE_PHASE_PWM});
    width(1'b0, n);
    chk("phase inv low", 128, n);
    ovf_seen();
    // Jump above the compare value just after bottom: up-match is missed
    wr(REG_COUNT, 8'd100);
    width(1'b1, n);
    chk("phase missed match", 191, n);
    setup(MODE_PHASE_PWM, CMP_CLEAR, 8'h00);
    hold(1'b0, 1100);
    setup(MODE_PHASE_PWM, CMP_CLEAR, 8'hff);
    hold(1'b1, 1100);
    setup(MODE_PHASE_PWM, CMP_SET, 8'h00);
    hold(1'b1, 1100);
    wr(REG_CTRL, {3'h0, 1'b0, CMP_SET, MODE_PHASE_PWM});
    repeat (4) @(posedge ref_clk_i);
    hold(1'b1, 50);
    chk("pin released", 1, oe_n);
    $display("test phase done");
    test_done();
  end
endmodule
bind timer8_ctc_pwm_waveform timer8_wave_checker chk_u (.ref_clk_i(ref_clk_i),
  .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .port_data_i(port_data_i), .wave_pin_o(wave_pin_o),
  .wave_pin_oe_n_o(wave_pin_oe_n_o), .compare_match_flag_o(compare_match_flag_o),
  .overflow_flag_o(overflow_flag_o));
`default_nettype wire
